// [design/spc_defs.svh]
// spc_defs.svh: bit positions, widths and timing counts of the serial
// converter control block. assumes inclusion by bare name, no other deps.
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH

`define SPC_SETUP_W 8
`define SPC_RES_W 12
`define SPC_WORD_W 16
`define SPC_LEAD_ZEROS 4
`define SPC_SETUP_RESET 8'h00
`define SPC_BIT_PM_LO 0
`define SPC_BIT_PM_HI 1
`define SPC_BIT_INSEL 3
`define SPC_BIT_CHCNT 4
`define SPC_BIT_REFDIS 5
// edges counted per frame, 5-bit counter
`define SPC_CNT_W 5
`define SPC_CNT_ZERO 5'h00
`define SPC_CNT_ONE 5'h01
`define SPC_SETUP_EDGES 5'h08
`define SPC_SAMPLE_RISE 5'h02
`define SPC_LAST_RISE 5'h10
// power mode codes
`define SPC_PM_GATED 2'h0
`define SPC_PM_ON 2'h1
`define SPC_PM_AUTO_OFF 2'h2
`define SPC_PM_AUTO_STBY 2'h3
// wake-up time from full shutdown, in ns, at a 5 ns clock
`define SPC_WAKE_NS 5000
`define SPC_CLK_NS 5
`define SPC_WAKE_CYC ((`SPC_WAKE_NS + `SPC_CLK_NS - 1) / `SPC_CLK_NS)
`define SPC_WAKE_W 10

`endif

// [design/spc_pkg.sv]
// spc_pkg: types shared by the serial converter control block.
// assumes spc_defs.svh is on the include path.
`include "spc_defs.svh"
package spc_pkg;
	typedef enum logic [3:0] {
		SPC_PWR_DOWN = 4'h1,
		SPC_PWR_WAKE = 4'h2,
		SPC_PWR_UP = 4'h4,
		SPC_PWR_STBY = 4'h8
	} spc_pwr_t;

	typedef struct packed {
		logic ref_disable;
		logic two_channel;
		logic input_select_bit;
		logic [1:0] power_mode_sel;
	} spc_cfg_t;

	typedef struct packed {
		logic core_on;
		logic ref_on;
		logic ready;
		logic ref_is_supply;
		logic ain1_sel;
	} spc_analog_t;
endpackage

// [design/spc_sync.sv]
// spc_sync: two-flop synchroniser for one pin-level input.
// assumes the input is asynchronous to i_ref_clk.
module spc_sync (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_pin,
	input wire logic i_rst_val,
	output logic o_level
);
	logic meta_q;
	logic meta_d;
	logic level_d;

	always_comb begin
		meta_d = i_pin;
		level_d = meta_q;
	end

	// reset value is a fixed zero here; i_rst_val does not set it
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= 1'b0;
			o_level <= 1'b0;
		end else begin
			meta_q <= meta_d;
			o_level <= level_d;
		end
	end
	// i_rst_val kept for sense; pins here read as 0 until sync warm-up ends
	logic unused_rst_val;
	assign unused_rst_val = i_rst_val;
endmodule

// [design/spc_sar.sv]
// spc_sar: successive-approximation search over 12 bits.
// assumes i_cmp is the comparator answer for the current trial, synchronous.
`include "spc_defs.svh"
module spc_sar
	import spc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_start,
	input wire logic i_step,
	input wire logic i_cmp,
	output logic [`SPC_RES_W-1:0] o_trial,
	output logic [`SPC_RES_W-1:0] o_result,
	output logic o_done
);
	logic [`SPC_RES_W-1:0] trial_q, trial_d;
	logic [`SPC_RES_W-1:0] mask_q, mask_d;
	logic [`SPC_RES_W-1:0] res_q, res_d;
	logic done_q, done_d;

	always_comb begin
		trial_d = trial_q;
		mask_d = mask_q;
		res_d = res_q;
		done_d = 1'b0;
		if (i_start) begin
			mask_d = {1'b1, {(`SPC_RES_W-1){1'b0}}};
			trial_d = mask_d;
		end else if (i_step && (mask_q != '0)) begin
			// keep the trial bit when input is at or above the trial level
			if (!i_cmp) begin
				trial_d = trial_q & ~mask_q;
			end
			mask_d = mask_q >> 1;
			trial_d = trial_d | (mask_q >> 1);
			if (mask_q[0]) begin
				// last trial bit decided: search ends, result latched
				res_d = i_cmp ? trial_q : (trial_q & ~mask_q);
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			trial_q <= '0;
			mask_q <= '0;
			res_q <= '0;
			done_q <= 1'b0;
		end else begin
			trial_q <= trial_d;
			mask_q <= mask_d;
			res_q <= res_d;
			done_q <= done_d;
		end
	end

	assign o_trial = trial_q;
	assign o_result = res_q;
	assign o_done = done_q;
endmodule

// [design/spc_top.sv]
// spc_top: serial control of a two-input 12-bit converter with power modes.
// assumes the host drives chip select, serial clock and config input as pins
// asynchronous to i_ref_clk; comparator answer arrives on i_cmp_hi.
`include "spc_defs.svh"
module spc_top
	import spc_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_cs_b,
	input wire logic i_sclk,
	input wire logic i_din,
	input wire logic i_cmp_hi,
	output logic o_dout,
	output logic o_dout_oe,
	output spc_analog_t o_analog,
	output logic [`SPC_RES_W-1:0] o_dac_trial,
	output logic o_sampling
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic cs_b_s, cs_sel_s, sclk_s, din_s, cmp_s;
	// select synced in its active sense: the zero reset of the flops then
	// reads as idle, so no false frame start follows reset
	spc_sync u_sync_cs (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
		.i_pin(~i_cs_b), .i_rst_val(1'b0), .o_level(cs_sel_s));
	assign cs_b_s = ~cs_sel_s;
	spc_sync u_sync_sclk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
		.i_pin(i_sclk), .i_rst_val(1'b0), .o_level(sclk_s));
	spc_sync u_sync_din (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
		.i_pin(i_din), .i_rst_val(1'b0), .o_level(din_s));
	spc_sync u_sync_cmp (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
		.i_pin(i_cmp_hi), .i_rst_val(1'b0), .o_level(cmp_s));

	// ------------------------------------------------------------
	// edge detection on synchronised levels
	// ------------------------------------------------------------
	// cs history resets high: a held-low select at release reads as a fall
	logic cs_prev_q, cs_prev_d, sclk_prev_q, sclk_prev_d;
	logic cs_fall, cs_rise, sclk_rise, sclk_fall, in_frame;

	always_comb begin
		cs_prev_d = cs_b_s;
		sclk_prev_d = sclk_s;
		cs_fall = cs_prev_q & ~cs_b_s;
		cs_rise = ~cs_prev_q & cs_b_s;
		in_frame = ~cs_b_s;
		sclk_rise = in_frame & sclk_s & ~sclk_prev_q;
		sclk_fall = in_frame & ~sclk_s & sclk_prev_q;
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cs_prev_q <= 1'b1;
			sclk_prev_q <= 1'b0;
		end else begin
			cs_prev_q <= cs_prev_d;
			sclk_prev_q <= sclk_prev_d;
		end
	end

	// ------------------------------------------------------------
	// frame counter, setup shift and setup word
	// ------------------------------------------------------------
	logic [`SPC_CNT_W-1:0] rise_cnt_q, rise_cnt_d;
	logic [`SPC_CNT_W-1:0] fall_cnt_q, fall_cnt_d;
	logic [`SPC_SETUP_W-1:0] shift_q, shift_d;
	logic [`SPC_SETUP_W-1:0] setup_q, setup_d;
	logic conv_end;
	spc_cfg_t cfg;

	always_comb begin
		rise_cnt_d = rise_cnt_q;
		fall_cnt_d = fall_cnt_q;
		shift_d = shift_q;
		setup_d = setup_q;
		if (cs_fall) begin
			rise_cnt_d = `SPC_CNT_ZERO;
			fall_cnt_d = `SPC_CNT_ZERO;
		end else begin
			if (sclk_rise && rise_cnt_q != `SPC_LAST_RISE) begin
				rise_cnt_d = rise_cnt_q + `SPC_CNT_ONE;
			end
			if (sclk_fall && fall_cnt_q != `SPC_LAST_RISE) begin
				fall_cnt_d = fall_cnt_q + `SPC_CNT_ONE;
			end
		end
		// config bit taken on each of the first eight falling serial edges
		if (sclk_fall && fall_cnt_q < `SPC_SETUP_EDGES) begin
			shift_d = {shift_q[`SPC_SETUP_W-2:0], din_s};
			if (fall_cnt_q == `SPC_SETUP_EDGES - `SPC_CNT_ONE) begin
				// a held-low input loads all zeros here
				setup_d = {shift_q[`SPC_SETUP_W-2:0], din_s};
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rise_cnt_q <= `SPC_CNT_ZERO;
			fall_cnt_q <= `SPC_CNT_ZERO;
			shift_q <= `SPC_SETUP_RESET;
			setup_q <= `SPC_SETUP_RESET;
		end else begin
			rise_cnt_q <= rise_cnt_d;
			fall_cnt_q <= fall_cnt_d;
			shift_q <= shift_d;
			setup_q <= setup_d;
		end
	end

	always_comb begin
		cfg.ref_disable = setup_q[`SPC_BIT_REFDIS];
		cfg.two_channel = setup_q[`SPC_BIT_CHCNT];
		cfg.input_select_bit = setup_q[`SPC_BIT_INSEL];
		cfg.power_mode_sel = {setup_q[`SPC_BIT_PM_HI],
			setup_q[`SPC_BIT_PM_LO]};
	end

	// ------------------------------------------------------------
	// conversion: sample on second rise, one trial per rise from the third to the fourteenth
	// ------------------------------------------------------------
	logic sar_start, sar_step;
	logic [`SPC_RES_W-1:0] sar_trial, sar_result;
	logic sar_done;

	always_comb begin
		sar_start = sclk_rise &&
			(rise_cnt_q == `SPC_SAMPLE_RISE - `SPC_CNT_ONE);
		sar_step = sclk_rise && (rise_cnt_q >= `SPC_SAMPLE_RISE) &&
			(rise_cnt_q < `SPC_LAST_RISE);
	end

	spc_sar u_sar (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_start(sar_start),
		.i_step(sar_step),
		.i_cmp(cmp_s),
		.o_trial(sar_trial),
		.o_result(sar_result),
		.o_done(sar_done)
	);
	// conversion is over on the sixteenth rise of the frame
	assign conv_end = sclk_rise &&
		(rise_cnt_q == `SPC_LAST_RISE - `SPC_CNT_ONE);

	// ------------------------------------------------------------
	// output shifter: 4 leading zeros then result msb first
	// ------------------------------------------------------------
	// word shows the last finished result; the current one lands late in
	// the frame, so a read returns the previous conversion
	logic [`SPC_WORD_W-1:0] out_q, out_d;
	logic [`SPC_RES_W-1:0] held_q, held_d;
	logic dout_q, dout_d, oe_q, oe_d;

	always_comb begin
		out_d = out_q;
		held_d = held_q;
		dout_d = dout_q;
		oe_d = in_frame;
		if (sar_done) begin
			held_d = sar_result;
		end
		if (cs_fall) begin
			// leading zero goes out now, so the shifter holds the rest
			out_d = {{(`SPC_LEAD_ZEROS-1){1'b0}}, held_q, 1'b0};
			dout_d = 1'b0;
		end else if (sclk_fall) begin
			dout_d = out_q[`SPC_WORD_W-1];
			out_d = {out_q[`SPC_WORD_W-2:0], 1'b0};
		end
		if (!in_frame) begin
			dout_d = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			out_q <= '0;
			held_q <= '0;
			dout_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			out_q <= out_d;
			held_q <= held_d;
			dout_q <= dout_d;
			oe_q <= oe_d;
		end
	end

	// ------------------------------------------------------------
	// power state machine
	// ------------------------------------------------------------
	spc_pwr_t pwr_q, pwr_d;
	logic [`SPC_WAKE_W-1:0] wake_q, wake_d;
	logic [`SPC_WAKE_W-1:0] wake_full;
	logic wake_req;

	always_comb begin
		wake_full = `SPC_WAKE_W'(`SPC_WAKE_CYC);
		pwr_d = pwr_q;
		wake_d = wake_q;
		wake_req = 1'b0;
		unique case (pwr_q)
			SPC_PWR_DOWN: begin
				if (cfg.power_mode_sel == `SPC_PM_GATED) begin
					wake_req = cs_fall;
				end else begin
					wake_req = sclk_fall && fall_cnt_q == `SPC_CNT_ZERO;
				end
			end
			SPC_PWR_STBY: begin
				wake_req = (cfg.power_mode_sel == `SPC_PM_GATED) ?
					cs_fall : (sclk_fall && fall_cnt_q == `SPC_CNT_ZERO);
			end
			SPC_PWR_WAKE: begin
				if (wake_q == '0) begin
					pwr_d = SPC_PWR_UP;
				end else begin
					wake_d = wake_q - `SPC_WAKE_W'(1);
				end
			end
			SPC_PWR_UP: begin
			end
		endcase
		if (wake_req) begin
			pwr_d = SPC_PWR_WAKE;
			// standby keeps the reference up, so wake is short
			wake_d = (pwr_q == SPC_PWR_STBY) ?
				`SPC_WAKE_W'(`SPC_WAKE_CYC / 5) : wake_full;
		end
		unique case (cfg.power_mode_sel)
			`SPC_PM_ON: begin
				pwr_d = SPC_PWR_UP;
			end
			`SPC_PM_GATED: begin
				if (cs_rise || (cs_b_s && !wake_req)) begin
					pwr_d = SPC_PWR_DOWN;
				end
			end
			`SPC_PM_AUTO_OFF: begin
				if (conv_end) begin
					pwr_d = SPC_PWR_DOWN;
				end
			end
			`SPC_PM_AUTO_STBY: begin
				if (conv_end) begin
					pwr_d = SPC_PWR_STBY;
				end
			end
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pwr_q <= SPC_PWR_DOWN;
			wake_q <= '0;
		end else begin
			pwr_q <= pwr_d;
			wake_q <= wake_d;
		end
	end

	// ------------------------------------------------------------
	// analog controls, all registered
	// ------------------------------------------------------------
	spc_analog_t ana_q, ana_d;
	logic [`SPC_RES_W-1:0] trial_q;
	logic samp_q, samp_d;

	always_comb begin
		ana_d.core_on = (pwr_d == SPC_PWR_UP) || (pwr_d == SPC_PWR_WAKE);
		ana_d.ready = (pwr_d == SPC_PWR_UP);
		ana_d.ref_on = !cfg.ref_disable && (pwr_d != SPC_PWR_DOWN);
		ana_d.ref_is_supply = cfg.two_channel;
		ana_d.ain1_sel = cfg.two_channel & cfg.input_select_bit;
		samp_d = in_frame && (rise_cnt_q < `SPC_SAMPLE_RISE);
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ana_q <= '0;
			trial_q <= '0;
			samp_q <= 1'b0;
		end else begin
			ana_q <= ana_d;
			trial_q <= sar_trial;
			samp_q <= samp_d;
		end
	end

	assign o_dout = dout_q;
	assign o_dout_oe = oe_q;
	assign o_analog = ana_q;
	assign o_dac_trial = trial_q;
	assign o_sampling = samp_q;
endmodule

// [test/spc_host.sv]
// spc_host.sv: behavioural serial master on the converter link.
// assumes the caller picks setup words and the lead-in before clocking.
module spc_host (
	output logic o_cs_b,
	output logic o_sclk,
	output logic o_din,
	input wire logic i_dout
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// link drive
	// ----
	initial begin
		o_cs_b = 1'b1;
		o_sclk = 1'b1;
		o_din = 1'b0;
	end
	// sclk idles high and stands still between frames
	task automatic xfer(input logic [7:0] setup, input int wait_ns,
		input int n, output logic [15:0] word);
		logic [7:0] s;
		s = setup & 8'hBB;
		word = 16'h0000;
		o_cs_b = 1'b0;
		#(wait_ns);
		for (int k = 0; k < n; k++) begin
			// past the setup bits the line wanders so it cannot be trusted
			o_din = (k < 8) ? s[7 - k] : ~o_din;
			#62.5;
			word[15 - k] = i_dout;
			o_sclk = 1'b0;
			#62.5;
			o_sclk = 1'b1;
		end
		#100;
		o_cs_b = 1'b1;
		#200;
	endtask
endmodule

// [test/spc_chk.sv]
// spc_chk.sv: port-level assertions on spc_top, bound at the foot.
// assumes spc_pkg is compiled first; pins are asynchronous to the clock.
module spc_chk (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_cs_b,
	input wire logic i_sclk,
	input wire logic i_din,
	input wire logic o_dout,
	input wire logic o_dout_oe,
	input wire spc_pkg::spc_analog_t o_analog,
	input wire logic o_sampling
);
	import spc_pkg::*;
	// ----
	// shadow of the link from raw pins
	// ----
	logic sck_q, sck_d;
	logic [4:0] nf_q, nf_d, nr_q, nr_d;
	logic [7:0] sh_q, sh_d, cfg_q, cfg_d;
	logic [3:0] age_q, age_d;
	logic [10:0] low_q, low_d;
	wire fall = sck_q & ~i_sclk & ~i_cs_b;
	wire rise = ~sck_q & i_sclk & ~i_cs_b;
	always_comb begin
		sck_d = i_sclk;
		nf_d = i_cs_b ? 5'h00 : nf_q + {4'h0, fall};
		nr_d = i_cs_b ? 5'h00 : nr_q + {4'h0, rise};
		sh_d = fall ? {sh_q[6:0], i_din} : sh_q;
		// short frames never reach the load
		cfg_d = (fall && nf_q == 5'h07) ? sh_d : cfg_q;
		age_d = fall ? 4'h0 : age_q + {3'h0, ~&age_q};
		low_d = o_analog.ready ? 11'h000 : low_q + {10'h000, ~&low_q};
	end
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{sck_q, nf_q, nr_q, sh_q, cfg_q, age_q, low_q} <= '0;
		end else begin
			{sck_q, nf_q, nr_q, sh_q, cfg_q, age_q, low_q} <=
				{sck_d, nf_d, nr_d, sh_d, cfg_d, age_d, low_d};
		end
	end
	// ----
	// assertions
	// ----
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_b);
	sequence conv_end;
		rise && nr_q == 5'h0F;
	endsequence
	frame_oe_a: assert property ($fell(i_cs_b) |-> ##[1:6] o_dout_oe)
		else $error("output enable late");
	track_start_a: assert property ($fell(i_cs_b) |-> ##[1:6] o_sampling)
		else $error("tracking late");
	dout_idle_a: assert property (!o_dout_oe [*3] |-> !o_dout)
		else $error("data out active outside frame");
	dout_pace_a: assert property (o_dout_oe && !i_cs_b && $changed(o_dout)
		|-> age_q < 4'h8) else $error("data out moved off a clock fall");
	gated_down_a: assert property ((cfg_q[1:0] == 2'h0 && i_cs_b) [*8]
		|-> !o_analog.core_on && !o_analog.ready) else $error("not down");
	always_on_a: assert property ($past(cfg_q[1:0], 8) == 2'h1
		&& cfg_q[1:0] == 2'h1 |-> o_analog.core_on) else $error("core off");
	auto_off_a: assert property (conv_end ##0 (cfg_q[1:0] == 2'h2)
		|-> ##[1:8] !o_analog.core_on) else $error("no shutdown");
	auto_stby_a: assert property (conv_end ##0 (cfg_q[1:0] == 2'h3
		&& !cfg_q[5]) |-> ##[1:8] (!o_analog.ready && o_analog.ref_on))
		else $error("no standby");
	wake_len_a: assert property ($rose(o_analog.ready) |-> low_q >= 11'h0C7)
		else $error("wake too short");
	ref_cfg_a: assert property ($stable(cfg_q) [*8] ##0 o_analog.ready
		|-> o_analog.ref_on != cfg_q[5] && o_analog.ref_is_supply == cfg_q[4])
		else $error("reference flags wrong");
endmodule

bind spc_top spc_chk u_chk (.i_ref_clk, .i_rst_b, .i_cs_b, .i_sclk,
	.i_din, .o_dout, .o_dout_oe, .o_analog, .o_sampling);

// [test/spc_top_tb.sv]
// spc_top_tb.sv: self-checking bench for spc_top with a host link model.
// assumes spc_host and spc_chk are compiled before this file.
module spc_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import spc_pkg::*;
	typedef struct {
		logic [7:0] setup;
		int wait_ns;
		logic [4:0] exp;
	} spc_row_t;
	// ----
	// frames: setup word, lead-in, analog flags after the frame
	// ----
	spc_row_t rows [9] = '{
		'{8'h01, 5000, 5'h1C},
		'{8'h31, 200, 5'h16},
		'{8'h39, 200, 5'h17},
		'{8'h12, 200, 5'h02},
		'{8'h03, 5000, 5'h08},
		'{8'h03, 1000, 5'h08},
		'{8'h00, 1000, 5'h00},
		'{8'h80, 5000, 5'h00},
		'{8'h01, 5000, 5'h1C}
	};
	logic i_ref_clk, i_rst_b, i_cs_b, i_sclk, i_din, i_cmp_hi;
	logic o_dout, o_dout_oe, o_sampling, sel;
	spc_analog_t o_analog;
	logic [11:0] o_dac_trial, exp_res;
	logic [11:0] vin [2] = '{12'hA5C, 12'h3F1};
	logic [11:0] vin_held = 12'h000;
	logic [15:0] word;
	int num_errors = 0;
	int n_compared = 0;
	// ideal track-and-hold: input frozen when tracking ends, so a channel
	// change later in the frame cannot disturb the running search
	always @(negedge o_sampling) vin_held = vin[o_analog.ain1_sel];
	assign i_cmp_hi = vin_held >= o_dac_trial;
	spc_top dut (.i_ref_clk, .i_rst_b, .i_cs_b, .i_sclk, .i_din, .i_cmp_hi,
		.o_dout, .o_dout_oe, .o_analog, .o_dac_trial, .o_sampling);
	spc_host host (.o_cs_b(i_cs_b), .o_sclk(i_sclk), .o_din(i_din),
		.i_dout(o_dout));
	initial begin
		i_ref_clk = 1'b0;
		forever #2.5 i_ref_clk = ~i_ref_clk;
	end
	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		if (num_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		test_done();
	end
	initial begin
		i_rst_b = 1'b0;
		sel = 1'b0;
		exp_res = 12'h000;
		repeat (16) @(posedge i_ref_clk);
		#1 i_rst_b = 1'b1;
		repeat (4) @(posedge i_ref_clk);
		#1;
		for (int i = 0; i < 9; i++) begin
			host.xfer(rows[i].setup, rows[i].wait_ns, 16, word);
			if (i > 0) check({4'h0, word}, {8'h00, exp_res});
			// result of a frame shows one frame later
			exp_res = vin[sel];
			sel = rows[i].setup[3];
			check({15'h0, o_analog}, {15'h0, rows[i].exp});
		end
		host.xfer(8'h02, 200, 4, word);
		check({19'h0, o_analog.core_on}, 20'h00001);
		host.xfer(8'h00, 200, 16, word);
		fork
			host.xfer(8'h00, 3000, 16, word);
			#1000 check({19'h0, o_analog.core_on}, 20'h00001);
		join
		check({15'h0, o_analog}, 20'h00000);
		@(posedge i_ref_clk);
		#1 i_rst_b = 1'b0;
		repeat (4) @(posedge i_ref_clk);
		check({o_dac_trial, o_dout, o_dout_oe, o_sampling, o_analog},
			20'h00000);
		#1 i_rst_b = 1'b1;
		repeat (4) @(posedge i_ref_clk);
		#1;
		host.xfer(8'h00, 5000, 16, word);
		host.xfer(8'h00, 5000, 16, word);
		check({4'h0, word}, {8'h00, vin[0]});
		test_done();
	end
endmodule
